// [include/adcrf_defines.svh]
// Constants of the converter result formatter and input selection block:
// register offsets, field positions, reset values and timing counts.
// Assumes byte addressing on a 32-bit APB with one register per word.
`ifndef ADCRF_DEFINES_SVH
`define ADCRF_DEFINES_SVH

// Register byte offsets
`define ADCRF_OFS_CTRL 8'h00
`define ADCRF_OFS_MUX 8'h04
`define ADCRF_OFS_CMD 8'h08
`define ADCRF_OFS_SAMP 8'h0c
`define ADCRF_OFS_CONVERTER_CONTROL_D 8'h10
`define ADCRF_OFS_RESULT 8'h14
`define ADCRF_OFS_STATUS 8'h18
`define ADCRF_OFS_SLOPE 8'h1c
`define ADCRF_OFS_OFFSET 8'h20

// Control register fields
`define ADCRF_CTRL_DIFF 1
`define ADCRF_CTRL_LEFT 2
`define ADCRF_CTRL_ACC_LSB 4
`define ADCRF_CTRL_PRE_LSB 8
// Input selection register fields
`define ADCRF_MUX_POS_LSB 0
`define ADCRF_MUX_NEG_LSB 8

// Reset values
`define ADCRF_CTRL_RST 12'h000
`define ADCRF_SAMP_RST 8'h00
`define ADCRF_INIT_RST 3'h0

// Timing in converter clock ticks
`define ADCRF_CONV_TICKS 6'h0d
`define ADCRF_SAMPLE_BASE 9'h002
`define ADCRF_INIT_STEP 7'h10

// Factory compensation defaults, arbitrary values
`define ADCRF_SLOPE_DEF 16'h1234
`define ADCRF_OFFSET_DEF 16'h5678

`endif

// [include/adcrf_pkg.sv]
// Types shared by the converter result formatter and selection logic.
// Assumes the constants header is compiled alongside.
package adcrf_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_INIT,
        ST_SAMPLE,
        ST_CONVERT
    } adcrf_state_t;
    typedef logic [2:0] adcrf_accnum_t;
    typedef logic [6:0] adcrf_sel_t;
endpackage

// [hdl/adcrf_result_pack.sv]
// Packs a signed or unsigned accumulated sum into the 16-bit result.
// Assumes the sum is already sign or zero extended to 20 bits.
`timescale 1ns/1ps
`default_nettype none
module adcrf_result_pack (
    input wire logic [19:0] acc_sum,
    input wire adcrf_pkg::adcrf_accnum_t acc_count,
    input wire logic left_align_select,
    output logic [15:0] packed_result
);
    // Wide sums keep their extension bits, so right adjust is a plain slice
    always_comb begin
        case (acc_count)
            3'h0: packed_result = left_align_select ?
                {acc_sum[11:0], 4'h0} : acc_sum[15:0]; // RULE_01
            3'h1: packed_result = left_align_select ?
                {acc_sum[12:0], 3'h0} : acc_sum[15:0]; // RULE_02
            3'h2: packed_result = left_align_select ?
                {acc_sum[13:0], 2'h0} : acc_sum[15:0]; // RULE_17
            3'h3: packed_result = left_align_select ?
                {acc_sum[14:0], 1'h0} : acc_sum[15:0]; // RULE_17
            3'h4: packed_result = acc_sum[15:0]; // RULE_18
            // Low bits dropped to fit, same for both adjust settings
            3'h5: packed_result = acc_sum[16:1]; // RULE_03
            3'h6: packed_result = acc_sum[17:2]; // RULE_03
            3'h7: packed_result = acc_sum[18:3]; // RULE_03
            default: packed_result = acc_sum[15:0];
        endcase
    end
endmodule
`default_nettype wire

// [hdl/adcrf_sel_hold.sv]
// Holding and active copies of the positive and negative input selections.
// Assumes lock is high while the converter must see a frozen selection.
`timescale 1ns/1ps
`default_nettype none
module adcrf_sel_hold (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sel_we,
    input wire logic [13:0] sel_wdata,
    input wire logic lock,
    output logic [13:0] sel_held,
    output logic [13:0] sel_active
);
    // Channel 0 is the positive selection, channel 1 the negative one
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            // Writes always land in the holding copy
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    sel_held[ch*7 +: 7] <= 7'h00;
                end else if (sel_we) begin
                    sel_held[ch*7 +: 7] <= sel_wdata[ch*7 +: 7]; // RULE_05
                end
            end
            // Active copy follows every cycle unless frozen
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    sel_active[ch*7 +: 7] <= 7'h00;
                end else if (!lock) begin
                    sel_active[ch*7 +: 7] <= sel_held[ch*7 +: 7]; // RULE_06
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [hdl/adcrf_top.sv]
// Converter back end: APB registers, converter clock divider, conversion
// sequencer with accumulation, input selection locking and result packing.
// Assumes the analog core returns conv_code valid at the end of conversion.
// Notes on behaviour
// [RULE_01] Single differential: 12-bit signed, extended or left-shifted
// [RULE_02] Two samples: 13-bit signed sum, same packing
// [RULE_03] 32 to 128 samples: truncate, ignore adjust
// [RULE_04] Negative selection used only when differential
// [RULE_05] Selection writes pass through a holding register
// [RULE_06] Idle: active selection copies held selection
// [RULE_07] Conversion start freezes active selections
// [RULE_08] Unfreeze in last converter cycle of conversion
// [RULE_09] Start on next converter tick after go
// [RULE_10] Software picks 2.048V reference and sensor
// [RULE_11] Software sets init delay for 25 us
// [RULE_12] Software sets sample length for 28 us
// [RULE_13] Software uses 12-bit right-adjusted single-ended reads
// [RULE_14] Factory slope and offset values readable
// [RULE_15] Software computes kelvin from offset, slope
// [RULE_16] Software rescales factors for other references
// [RULE_17] Four and eight samples: 14 and 15 bits
// [RULE_18] Sixteen samples fill all sixteen bits
// [RULE_19] Left adjust puts top bits in high byte
// [RULE_20] Differential two's complement, single-ended unsigned
`timescale 1ns/1ps
`default_nettype none
`include "adcrf_defines.svh"
module adcrf_top #(
    parameter logic [15:0] SLOPE_FACTORY = `ADCRF_SLOPE_DEF,
    parameter logic [15:0] OFFSET_FACTORY = `ADCRF_OFFSET_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] conv_code,
    output logic sample_en,
    output logic conv_done,
    output logic [6:0] positive_input_select,
    output logic [6:0] negative_input_select,
    output logic negative_input_enable
);
    // Software-visible control state
    logic [11:0] ctrl_reg;
    logic [7:0] sample_length_field;
    logic [2:0] init_delay_field;
    logic [15:0] result_register;
    logic conversion_go_bit;
    logic result_ready_reg;
    logic [13:0] sel_held;
    logic [13:0] sel_active;
    // Sequencer state
    adcrf_pkg::adcrf_state_t state_reg;
    logic [9:0] cnt_reg;
    logic [7:0] sample_idx_reg;
    logic [19:0] acc_reg;
    logic [3:0] pre_cnt_reg;
    logic tick;
    logic lock;
    logic last_conv_cycle;
    logic last_sample;
    logic res_load;
    logic [19:0] code_ext;
    logic [19:0] acc_next;
    logic [15:0] packed_result;
    // APB decode
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [31:0] rd_next;

    logic diff_mode;
    logic left_align_select;
    adcrf_pkg::adcrf_accnum_t acc_count;
    logic [3:0] prescale;
    assign diff_mode = ctrl_reg[`ADCRF_CTRL_DIFF];
    assign left_align_select = ctrl_reg[`ADCRF_CTRL_LEFT];
    assign acc_count = ctrl_reg[`ADCRF_CTRL_ACC_LSB +: 3];
    assign prescale = ctrl_reg[`ADCRF_CTRL_PRE_LSB +: 4];

    // Zero wait state slave; writes commit in the access phase
    assign pready = 1'h1;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !addr_ok;

    // Address decode shared by read and write paths
    always_comb begin
        case (paddr)
            `ADCRF_OFS_CTRL, `ADCRF_OFS_MUX, `ADCRF_OFS_CMD,
            `ADCRF_OFS_SAMP, `ADCRF_OFS_CONVERTER_CONTROL_D, `ADCRF_OFS_RESULT,
            `ADCRF_OFS_STATUS, `ADCRF_OFS_SLOPE,
            `ADCRF_OFS_OFFSET: addr_ok = 1'h1;
            default: addr_ok = 1'h0;
        endcase
    end

    // Read mux; active selections are shown so software sees the lock
    always_comb begin
        case (paddr)
            `ADCRF_OFS_CTRL: rd_next = {20'h00000, ctrl_reg};
            `ADCRF_OFS_MUX: rd_next = {17'h00000, sel_held[13:7],
                1'h0, sel_held[6:0]};
            `ADCRF_OFS_CMD: rd_next = {31'h00000000, conversion_go_bit};
            `ADCRF_OFS_SAMP: rd_next = {24'h000000, sample_length_field};
            `ADCRF_OFS_CONVERTER_CONTROL_D: rd_next = {29'h00000000, init_delay_field};
            `ADCRF_OFS_RESULT: rd_next = {16'h0000, result_register};
            `ADCRF_OFS_STATUS: rd_next = {9'h000, sel_active[13:7], 1'h0,
                sel_active[6:0], 6'h00, result_ready_reg, conversion_go_bit};
            `ADCRF_OFS_SLOPE: rd_next = {16'h0000, SLOPE_FACTORY}; // RULE_14
            `ADCRF_OFS_OFFSET: rd_next = {16'h0000, OFFSET_FACTORY}; // RULE_14
            default: rd_next = 32'h00000000;
        endcase
    end

    // Read data captured in the setup phase, stable through access
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= rd_next;
        end
    end

    // Configuration registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= `ADCRF_CTRL_RST;
            sample_length_field <= `ADCRF_SAMP_RST;
            init_delay_field <= `ADCRF_INIT_RST;
        end else if (wr_en) begin
            if (paddr == `ADCRF_OFS_CTRL) begin
                ctrl_reg <= pwdata[11:0];
            end
            if (paddr == `ADCRF_OFS_SAMP) begin
                sample_length_field <= pwdata[7:0];
            end
            if (paddr == `ADCRF_OFS_CONVERTER_CONTROL_D) begin
                init_delay_field <= pwdata[2:0];
            end
        end
    end

    // Converter clock: one-cycle enable every prescale+1 system cycles
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_cnt_reg <= 4'h0;
        end else if (pre_cnt_reg >= prescale) begin
            pre_cnt_reg <= 4'h0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 4'h1;
        end
    end
    assign tick = (pre_cnt_reg >= prescale);

    // Selections are locked from start up to the final converter cycle of each sample conversion
    assign last_conv_cycle = (state_reg == adcrf_pkg::ST_CONVERT) &&
        (cnt_reg == 10'h000);
    assign lock = (state_reg != adcrf_pkg::ST_IDLE) &&
        !last_conv_cycle; // RULE_07 RULE_08
    assign last_sample = (sample_idx_reg ==
        8'((9'h001 << acc_count) - 9'h001));
    assign res_load = last_conv_cycle && tick && last_sample;

    adcrf_sel_hold i_adcrf_sel_hold (
        .clk(clk),
        .rstn(rstn),
        .sel_we(wr_en && (paddr == `ADCRF_OFS_MUX)),
        .sel_wdata({pwdata[`ADCRF_MUX_NEG_LSB +: 7],
            pwdata[`ADCRF_MUX_POS_LSB +: 7]}),
        .lock(lock),
        .sel_held(sel_held),
        .sel_active(sel_active)
    );

    // Negative selection only reaches the converter in differential mode
    assign positive_input_select = sel_active[6:0];
    assign negative_input_select = diff_mode ? sel_active[13:7] :
        7'h00; // RULE_04
    assign negative_input_enable = diff_mode; // RULE_04

    // Go bit: set by software, cleared by hardware at the end; set wins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conversion_go_bit <= 1'h0;
        end else if (wr_en && paddr == `ADCRF_OFS_CMD && pwdata[0]) begin
            conversion_go_bit <= 1'h1;
        end else if (res_load) begin
            conversion_go_bit <= 1'h0;
        end
    end

    // Sequencer: init delay once, then sample and convert per accumulation
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= adcrf_pkg::ST_IDLE;
            cnt_reg <= 10'h000;
        end else if (tick) begin
            case (state_reg)
                adcrf_pkg::ST_IDLE: begin
                    if (conversion_go_bit) begin
                        state_reg <= adcrf_pkg::ST_INIT; // RULE_09
                        cnt_reg <= 10'(init_delay_field * `ADCRF_INIT_STEP);
                    end
                end
                adcrf_pkg::ST_INIT: begin
                    if (cnt_reg == 10'h000) begin
                        state_reg <= adcrf_pkg::ST_SAMPLE;
                        cnt_reg <= 10'(sample_length_field +
                            `ADCRF_SAMPLE_BASE);
                    end else begin
                        cnt_reg <= cnt_reg - 10'h001;
                    end
                end
                adcrf_pkg::ST_SAMPLE: begin
                    if (cnt_reg == 10'h000) begin
                        state_reg <= adcrf_pkg::ST_CONVERT;
                        cnt_reg <= 10'(`ADCRF_CONV_TICKS - 6'h01);
                    end else begin
                        cnt_reg <= cnt_reg - 10'h001;
                    end
                end
                adcrf_pkg::ST_CONVERT: begin
                    if (cnt_reg != 10'h000) begin
                        cnt_reg <= cnt_reg - 10'h001;
                    end else if (last_sample) begin
                        state_reg <= adcrf_pkg::ST_IDLE;
                    end else begin
                        state_reg <= adcrf_pkg::ST_SAMPLE;
                        cnt_reg <= 10'(sample_length_field +
                            `ADCRF_SAMPLE_BASE);
                    end
                end
                default: begin
                    state_reg <= adcrf_pkg::ST_IDLE;
                    cnt_reg <= 10'h000;
                end
            endcase
        end
    end

    // Analog sampling window
    assign sample_en = (state_reg == adcrf_pkg::ST_SAMPLE);

    // Differential codes are signed, single-ended codes unsigned
    assign code_ext = diff_mode ? {{8{conv_code[11]}}, conv_code} :
        {8'h00, conv_code}; // RULE_20
    assign acc_next = acc_reg + code_ext;

    // Accumulator and sample index
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_reg <= 20'h00000;
            sample_idx_reg <= 8'h00;
        end else if (state_reg == adcrf_pkg::ST_IDLE) begin
            acc_reg <= 20'h00000;
            sample_idx_reg <= 8'h00;
        end else if (last_conv_cycle && tick) begin
            acc_reg <= acc_next;
            sample_idx_reg <= sample_idx_reg + 8'h01;
        end
    end

    adcrf_result_pack i_adcrf_result_pack (
        .acc_sum(acc_next),
        .acc_count(acc_count),
        .left_align_select(left_align_select),
        .packed_result(packed_result)
    );

    // Result register and its ready flag; a new result beats a read clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result_register <= 16'h0000;
            result_ready_reg <= 1'h0;
            conv_done <= 1'h0;
        end else begin
            conv_done <= res_load;
            if (res_load) begin
                result_register <= packed_result; // RULE_19
                result_ready_reg <= 1'h1;
            end else if (rd_setup && paddr == `ADCRF_OFS_RESULT) begin
                result_ready_reg <= 1'h0;
            end
        end
    end

    // Checks on sequencing, locking and packing
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_start;
        state_reg == adcrf_pkg::ST_IDLE && conversion_go_bit && tick;
    endsequence

    sequence s_load_diff(logic [2:0] n, logic l);
        res_load && diff_mode && acc_count == n && left_align_select == l;
    endsequence

    // Helper: sum shifted down by one bit per doubling beyond sixteen
    logic [15:0] trunc_chk;
    always_comb begin
        trunc_chk = 16'(acc_next >> (acc_count - 3'h4));
    end

    go_start_a: assert property (s_start |=> // RULE_09
        state_reg == adcrf_pkg::ST_INIT && lock)
        else $error("conversion did not start on converter tick");
    sel_freeze_a: assert property (lock && $past(lock) |-> // RULE_07
        $stable(sel_active))
        else $error("active selection changed while locked");
    sel_follow_a: assert property (!lock |=> // RULE_06
        sel_active == $past(sel_held))
        else $error("active selection did not follow held value");
    sel_release_a: assert property (last_conv_cycle |=> // RULE_08
        sel_active == $past(sel_held))
        else $error("selection not copied in last converter cycle");
    neg_gate_a: assert property (!diff_mode |-> // RULE_04
        negative_input_select == 7'h00)
        else $error("negative selection driven in single-ended mode");
    single_right_a: assert property (s_load_diff(3'h0, 1'h0) |=> // RULE_01
        result_register == {{4{$past(acc_next[11])}}, $past(acc_next[11:0])})
        else $error("single differential right format wrong");
    single_left_a: assert property (s_load_diff(3'h0, 1'h1) |=> // RULE_01
        result_register == {$past(acc_next[11:0]), 4'h0})
        else $error("single differential left format wrong");
    two_left_a: assert property (s_load_diff(3'h1, 1'h1) |=> // RULE_02
        result_register == {$past(acc_next[12:0]), 3'h0})
        else $error("two sample left format wrong");
    four_left_a: assert property (s_load_diff(3'h2, 1'h1) |=> // RULE_17
        result_register == {$past(acc_next[13:0]), 2'h0})
        else $error("four sample left format wrong");
    sixteen_full_a: assert property (res_load && // RULE_18
        acc_count == 3'h4 |=> result_register == $past(acc_next[15:0]))
        else $error("sixteen sample format wrong");
    trunc_fit_a: assert property (res_load && acc_count > 3'h4 |=> // RULE_03
        result_register == $past(trunc_chk))
        else $error("truncated accumulation wrong");
endmodule
`default_nettype wire

// [dv/adc_result_format_mux_select_bench.sv]
// Self-checking bench for the converter back end: result packing per
// accumulation count, selection locking around a conversion, registers.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "adcrf_defines.svh"
module adc_result_format_mux_select_bench;
    typedef struct {
        logic [31:0] e;
        logic [31:0] m;
        logic err;
    } adcrf_exp_t;
    logic clk;
    logic rstn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] conv_code;
    logic sample_en;
    logic conv_done;
    logic [6:0] pos_sel;
    logic [6:0] neg_sel;
    logic neg_en;
    // Temperature sensor channel code, arbitrary value
    localparam logic [6:0] TEMP_CH = 7'h2a;
    int miscompares = 0;
    int cmp_count = 0;
    adcrf_exp_t expq[$];
    adcrf_top i_adcrf_top (
        .clk(clk),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .conv_code(conv_code),
        .sample_en(sample_en),
        .conv_done(conv_done),
        .positive_input_select(pos_sel),
        .negative_input_select(neg_sel),
        .negative_input_enable(neg_en)
    );
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // One APB transfer; a read notes its expected word before the request
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] m);
        int k;
        adcrf_exp_t x;
        k = 0;
        x.e = d;
        x.m = m;
        x.err = (a > `ADCRF_OFS_OFFSET);
        if (!wr) begin
            expq.push_back(x);
        end
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            miscompares++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read data and error flag are taken at the completing access edge
    always @(posedge clk) begin
        adcrf_exp_t x;
        if (psel && penable && !pwrite && pready === 1'b1) begin
            x = expq.pop_front();
            check(prdata & x.m, x.e & x.m);
            check({31'h0, pslverr}, {31'h0, x.err});
        end
    end
    // Bounded wait for the end-of-result pulse
    task automatic wait_done();
        int k;
        k = 0;
        while (conv_done !== 1'b1 && k < 8000) begin
            @(negedge clk);
            k++;
        end
        check({31'h0, conv_done}, 32'h1);
    endtask
    task automatic pins(input logic [6:0] p, input logic [6:0] n,
                        input logic e);
        // Active copy trails the held copy by one clock
        @(posedge clk);
        @(negedge clk);
        check({16'h0, e, pos_sel, 1'b0, neg_sel}, {16'h0, e, p, 1'b0, n});
    endtask
    // Expected packing; sums over 16 samples lose low bits to fit 16 bits
    function automatic logic [15:0] fmt(input logic [11:0] c, input int n,
                                        input logic l, input logic d);
        logic signed [19:0] s;
        s = d ? {{8{c[11]}}, c} : {8'h00, c};
        s = s <<< n;
        if (n > 4) begin
            return 16'(s >>> (n - 4));
        end
        return l ? 16'(s <<< (4 - n)) : s[15:0];
    endfunction
    initial begin
        #(60000 * 25);
        miscompares++;
        conclude();
    end
    initial begin
        logic [11:0] c;
        logic [6:0] p1, n1, p2, n2;
        logic [7:0] sl;
        int k;
        logic [31:0] tk1, tk2;
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_code = 12'h000;
        void'($urandom(99));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        apb(0, `ADCRF_OFS_CTRL, 32'h0, 32'hfff);
        apb(0, `ADCRF_OFS_SLOPE, 32'(`ADCRF_SLOPE_DEF), 32'hffff);
        apb(0, `ADCRF_OFS_OFFSET, 32'(`ADCRF_OFFSET_DEF), 32'hffff);
        apb(0, 8'h24, 32'h0, 32'hffffffff);
        sl = 8'($urandom % 4);
        apb(1, `ADCRF_OFS_SAMP, {24'h0, sl}, 0);
        apb(0, `ADCRF_OFS_SAMP, {24'h0, sl}, 32'hff);
        apb(1, `ADCRF_OFS_CONVERTER_CONTROL_D, 32'h1, 0);
        apb(0, `ADCRF_OFS_CONVERTER_CONTROL_D, 32'h1, 32'h7);
        // Every count, both adjust settings, both input modes
        for (int d = 0; d < 2; d++) begin
            for (int l = 0; l < 2; l++) begin
                for (int n = 0; n < 8; n++) begin
                    c = (n == 7) ? 12'h800 : 12'($urandom);
                    conv_code <= c;
                    apb(1, `ADCRF_OFS_CTRL,
                        32'((n << 4) | (l << 2) | (d << 1)), 0);
                    apb(1, `ADCRF_OFS_CMD, 32'h1, 0);
                    wait_done();
                    apb(0, `ADCRF_OFS_CMD, 32'h0, 32'h1);
                    apb(0, `ADCRF_OFS_RESULT,
                        {16'h0, fmt(c, n, l[0], d[0])},
                        32'hffff);
                end
            end
        end
        // Selection held while idle, frozen in conversion, released at end
        {p1, n1, p2, n2} = 28'($urandom);
        apb(1, `ADCRF_OFS_MUX, {17'h0, n1, 1'b0, p1}, 0);
        pins(p1, n1, 1'b1);
        apb(1, `ADCRF_OFS_CMD, 32'h1, 0);
        apb(1, `ADCRF_OFS_MUX, {17'h0, n2, 1'b0, p2}, 0);
        pins(p1, n1, 1'b1);
        apb(0, `ADCRF_OFS_MUX, {17'h0, n2, 1'b0, p2}, 32'h7f7f);
        apb(0, `ADCRF_OFS_STATUS, {9'h0, n1, 1'b0, p1, 8'h1},
            32'h7f7f01);
        wait_done();
        pins(p2, n2, 1'b1);
        apb(1, `ADCRF_OFS_CTRL, 32'h0, 0);
        pins(p2, 7'h00, 1'b0);
        // Temperature reading: sensor on the positive input, single-ended,
        // right adjusted; converter tick every 16 clocks so that the init
        // delay covers 25 us and sampling lasts 28 us (1120 clocks).
        // The 2.048 V reference is chosen outside this block.
        c = 12'($urandom) & 12'hffe;
        apb(1, `ADCRF_OFS_CTRL, 32'h00000f00, 0);
        conv_code <= c;
        apb(1, `ADCRF_OFS_SAMP, 32'h00000043, 0);
        apb(1, `ADCRF_OFS_CONVERTER_CONTROL_D, 32'h00000004, 0);
        apb(1, `ADCRF_OFS_MUX, {25'h0, TEMP_CH}, 0);
        pins(TEMP_CH, 7'h00, 1'b0);
        apb(1, `ADCRF_OFS_CMD, 32'h1, 0);
        k = 0;
        while (sample_en !== 1'b1 && k < 4000) begin
            @(negedge clk);
            k++;
        end
        k = 0;
        while (sample_en === 1'b1 && k < 4000) begin
            @(negedge clk);
            k++;
        end
        check(32'(k), 32'h00000460);
        wait_done();
        apb(0, `ADCRF_OFS_RESULT, {20'h0, c}, 32'hffff);
        // Kelvin in 32 bits; the same voltage read against a 4.096 V
        // reference, with rescaled factors, must give the same temperature
        tk1 = (32'(`ADCRF_OFFSET_DEF) - 32'(c)) * 32'(`ADCRF_SLOPE_DEF);
        tk1 = (tk1 + 32'h800) / 32'h1000;
        tk2 = 32'(`ADCRF_OFFSET_DEF) * 32'h800 / 32'h1000 - 32'(c >> 1);
        tk2 = tk2 * (32'(`ADCRF_SLOPE_DEF) * 32'h1000 / 32'h800);
        tk2 = (tk2 + 32'h800) / 32'h1000;
        check(tk2, tk1);
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
